// *** hdl/cmp_set_pkg.sv ***
/*
 * Package for the comparison-and-set ALU slot: opcodes, mode nibble
 * layout, result constants and reset values.
 * Assumes a single clock domain and a sequencer that issues whole words.
 */
package cmp_set_pkg;

    // ********************************************
    // Opcodes of the instruction field
    // ********************************************
    localparam logic [10:0] OP_SET_MODE = 11'h057;
    localparam logic [10:0] OP_FLOAT_EQ_TO_FLOAT = 11'h008;
    localparam logic [10:0] OP_FLOAT_GT_TO_FLOAT = 11'h009;
    localparam logic [10:0] OP_FLOAT_GE_TO_FLOAT = 11'h00a;
    localparam logic [10:0] OP_FLOAT_NE_TO_FLOAT = 11'h00b;
    localparam logic [10:0] OP_FLOAT_EQ_TO_MASK = 11'h00c;
    localparam logic [10:0] OP_FLOAT_GT_TO_MASK = 11'h00d;
    localparam logic [10:0] OP_FLOAT_GE_TO_MASK = 11'h00e;
    localparam logic [10:0] OP_FLOAT_NE_TO_MASK = 11'h00f;
    localparam logic [10:0] OP_INT_EQ_TO_MASK = 11'h03a;
    localparam logic [10:0] OP_SIGNED_GT_TO_MASK = 11'h03b;
    localparam logic [10:0] OP_SIGNED_GE_TO_MASK = 11'h03c;
    localparam logic [10:0] OP_INT_NE_TO_MASK = 11'h03d;
    localparam logic [10:0] OP_UNSIGNED_GT_TO_MASK = 11'h03e;
    localparam logic [10:0] OP_UNSIGNED_GE_TO_MASK = 11'h03f;
    localparam logic [10:0] OP_DOUBLE_EQ_NAMED_COMPARE = 11'h0b8;
    localparam logic [10:0] OP_DOUBLE_NE_TO_MASK = 11'h0b9;
    localparam logic [10:0] OP_DOUBLE_GT_TO_MASK = 11'h0ba;
    localparam logic [10:0] OP_DOUBLE_GE_TO_MASK = 11'h0bb;

    // ********************************************
    // Second word field positions
    // ********************************************
    localparam int OPCODE_LSB = 7;
    localparam int OPCODE_MSB = 17;

    // ********************************************
    // Mode nibble layout
    // ********************************************
    localparam int ROUND_LSB = 0;
    localparam int ROUND_MSB = 1;
    localparam int IN_DENORM_BIT = 2;
    localparam int OUT_DENORM_BIT = 3;
    localparam logic [1:0] ROUND_NEAREST_EVEN = 2'h0;
    localparam logic [1:0] ROUND_PLUS_INF = 2'h1;
    localparam logic [1:0] ROUND_MINUS_INF = 2'h2;
    localparam logic [1:0] ROUND_TO_ZERO = 2'h3;

    // ********************************************
    // Result values and reset values
    // ********************************************
    localparam logic [31:0] FLOAT_ONE = 32'h3f800000;
    localparam logic [31:0] FLOAT_ZERO = 32'h00000000;
    localparam logic [31:0] MASK_ONES = 32'hffffffff;
    localparam logic [63:0] MASK_ONES_64 = 64'hffffffffffffffff;
    localparam logic [3:0] MODE_RESET = 4'hc;
    localparam logic [63:0] RESULT_RESET = 64'h0000000000000000;

endpackage

// *** hdl/cmp_set_slot.sv ***
/*
 * Comparison-and-set slot of a vector ALU, with per-clause mode override.
 * Assumes the sequencer presents both instruction words and all source
 * operands in the cycle issue_i is high, and pulses clause_end_i at the end
 * of each clause. Results appear one cycle after issue.
 */
`timescale 1ns/1ps

// Overview of operation
// - Opcode 87 is the mode override
// - Override lasts to clause end; two nibbles
// - Bits 1:0 select the rounding mode
// - Bit 3 output, bit 2 input denormals
// - Opcode 8 float equal gives 1.0
// - Opcode 10 float greater-equal gives 1.0
// - Opcode 9 float greater gives 1.0
// - Opcode 11 float unequal gives 1.0
// - Opcode 12 float equal gives mask
// - Opcode 14 float greater-equal gives mask
// - Opcode 13 float greater gives mask
// - Opcode 15 float unequal gives mask
// - Opcode 58 bitwise integer equal mask
// - Opcode 60 signed greater-equal mask
// - Opcode 63 unsigned greater-equal mask
// - Opcode 59 signed greater mask
// - Opcode 62 unsigned greater mask
// - Integer not-equal mask, any signedness
// - Opcode 61 is integer not-equal
// - Opcode 184 behaves as double greater-equal
// - Opcode 187 double greater-equal 64-bit mask
// - Opcode 186 double greater 64-bit mask
// - Opcode 185 double unequal 64-bit mask
// - Double sets never touch predicate
module cmp_set_slot (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Instruction issue
    input wire logic issue_i,
    input wire logic [31:0] first_alu_word_i,
    input wire logic [31:0] second_alu_word_i,
    input wire logic clause_end_i,
    // Source operands
    input wire logic [31:0] src0_i,
    input wire logic [31:0] src1_i,
    input wire logic [31:0] src0_lo_i,
    input wire logic [31:0] src1_lo_i,
    // Results
    output logic result_valid_o,
    output logic [63:0] result_o,
    output logic result_is_64_o,
    output logic illegal_op_o,
    output logic predicate_write_o,
    // Active modes
    output logic [1:0] single_round_o,
    output logic single_in_denorm_o,
    output logic single_out_denorm_o,
    output logic [1:0] double_round_o,
    output logic double_in_denorm_o,
    output logic double_out_denorm_o
);

    // ********************************************
    // Decode and mode state
    // ********************************************
    logic [10:0] opcode;
    logic [3:0] single_mode_reg;
    logic [3:0] double_mode_reg;
    logic [3:0] first_sel_nibble;
    logic [3:0] second_sel_nibble;

    assign opcode = second_alu_word_i[cmp_set_pkg::OPCODE_MSB:cmp_set_pkg::OPCODE_LSB];
    assign first_sel_nibble = first_alu_word_i[3:0];
    assign second_sel_nibble = first_alu_word_i[16:13];

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            single_mode_reg <= cmp_set_pkg::MODE_RESET;
            double_mode_reg <= cmp_set_pkg::MODE_RESET;
        end
        else if (clk_en_i)
        begin
            if (issue_i && opcode == cmp_set_pkg::OP_SET_MODE)
            begin
                single_mode_reg <= first_sel_nibble;
                double_mode_reg <= second_sel_nibble;
            end
            else if (clause_end_i)
            begin
                single_mode_reg <= cmp_set_pkg::MODE_RESET;
                double_mode_reg <= cmp_set_pkg::MODE_RESET;
            end
        end
    end

    assign single_round_o = single_mode_reg[cmp_set_pkg::ROUND_MSB:cmp_set_pkg::ROUND_LSB];
    assign double_round_o = double_mode_reg[cmp_set_pkg::ROUND_MSB:cmp_set_pkg::ROUND_LSB];
    assign single_in_denorm_o = single_mode_reg[cmp_set_pkg::IN_DENORM_BIT];
    assign single_out_denorm_o = single_mode_reg[cmp_set_pkg::OUT_DENORM_BIT];
    assign double_in_denorm_o = double_mode_reg[cmp_set_pkg::IN_DENORM_BIT];
    assign double_out_denorm_o = double_mode_reg[cmp_set_pkg::OUT_DENORM_BIT];

    // ********************************************
    // Relations
    // ********************************************
    logic s_eq;
    logic s_gt;
    logic s_un;
    logic d_eq;
    logic d_gt;
    logic d_un;
    logic [63:0] d_a;
    logic [63:0] d_b;

    assign d_a = {src0_i, src0_lo_i};
    assign d_b = {src1_i, src1_lo_i};

    float_order #(
        .W(32),
        .EXP_W(8)
    ) single_cmp (
        .a_i(src0_i),
        .b_i(src1_i),
        .flush_i(!single_in_denorm_o),
        .eq_o(s_eq),
        .gt_o(s_gt),
        .unordered_o(s_un)
    );

    float_order #(
        .W(64),
        .EXP_W(11)
    ) double_cmp (
        .a_i(d_a),
        .b_i(d_b),
        .flush_i(!double_in_denorm_o),
        .eq_o(d_eq),
        .gt_o(d_gt),
        .unordered_o(d_un)
    );

    // ********************************************
    // Result select
    // ********************************************
    logic [63:0] result_next;
    logic wide_next;
    logic illegal_next;
    logic s_ge;
    logic d_ge;
    logic s_ne;
    logic d_ne;

    // Unordered pairs never count as greater-or-equal
    assign s_ge = (s_eq | s_gt) & !s_un;
    assign d_ge = (d_eq | d_gt) & !d_un;
    assign s_ne = !s_eq;
    assign d_ne = !d_eq;

    always_comb
    begin
        result_next = cmp_set_pkg::RESULT_RESET;
        wide_next = 1'b0;
        illegal_next = 1'b0;
        case (opcode)
            cmp_set_pkg::OP_FLOAT_EQ_TO_FLOAT:
                result_next[31:0] = s_eq ? cmp_set_pkg::FLOAT_ONE : cmp_set_pkg::FLOAT_ZERO;
            cmp_set_pkg::OP_FLOAT_GT_TO_FLOAT:
                result_next[31:0] = s_gt ? cmp_set_pkg::FLOAT_ONE : cmp_set_pkg::FLOAT_ZERO;
            cmp_set_pkg::OP_FLOAT_GE_TO_FLOAT:
                result_next[31:0] = s_ge ? cmp_set_pkg::FLOAT_ONE : cmp_set_pkg::FLOAT_ZERO;
            cmp_set_pkg::OP_FLOAT_NE_TO_FLOAT:
                result_next[31:0] = s_ne ? cmp_set_pkg::FLOAT_ONE : cmp_set_pkg::FLOAT_ZERO;
            cmp_set_pkg::OP_FLOAT_EQ_TO_MASK:
                result_next[31:0] = s_eq ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_FLOAT_GT_TO_MASK:
                result_next[31:0] = s_gt ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_FLOAT_GE_TO_MASK:
                result_next[31:0] = s_ge ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_FLOAT_NE_TO_MASK:
                result_next[31:0] = s_ne ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_INT_EQ_TO_MASK:
                result_next[31:0] = (src0_i == src1_i) ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_SIGNED_GT_TO_MASK:
                result_next[31:0] = ($signed(src0_i) > $signed(src1_i)) ?
                    cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_SIGNED_GE_TO_MASK:
                result_next[31:0] = ($signed(src0_i) >= $signed(src1_i)) ?
                    cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_INT_NE_TO_MASK:
                result_next[31:0] = (src0_i != src1_i) ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_UNSIGNED_GT_TO_MASK:
                result_next[31:0] = (src0_i > src1_i) ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_UNSIGNED_GE_TO_MASK:
                result_next[31:0] = (src0_i >= src1_i) ? cmp_set_pkg::MASK_ONES : '0;
            cmp_set_pkg::OP_DOUBLE_EQ_NAMED_COMPARE, cmp_set_pkg::OP_DOUBLE_GE_TO_MASK:
            begin
                // Named as equality but behaves as greater-or-equal
                result_next = d_ge ? cmp_set_pkg::MASK_ONES_64 : '0;
                wide_next = 1'b1;
            end
            cmp_set_pkg::OP_DOUBLE_GT_TO_MASK:
            begin
                result_next = d_gt ? cmp_set_pkg::MASK_ONES_64 : '0;
                wide_next = 1'b1;
            end
            cmp_set_pkg::OP_DOUBLE_NE_TO_MASK:
            begin
                result_next = d_ne ? cmp_set_pkg::MASK_ONES_64 : '0;
                wide_next = 1'b1;
            end
            cmp_set_pkg::OP_SET_MODE:
                result_next = cmp_set_pkg::RESULT_RESET;
            default:
                illegal_next = 1'b1;
        endcase
    end

    // ********************************************
    // Output registers
    // ********************************************
    logic valid_reg;
    logic [63:0] result_reg;
    logic wide_reg;
    logic illegal_reg;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            valid_reg <= 1'b0;
            result_reg <= cmp_set_pkg::RESULT_RESET;
            wide_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            valid_reg <= issue_i && opcode != cmp_set_pkg::OP_SET_MODE;
            illegal_reg <= issue_i && illegal_next;
            if (issue_i)
            begin
                result_reg <= result_next;
                wide_reg <= wide_next;
            end
        end
    end

    assign result_valid_o = valid_reg;
    assign result_o = result_reg;
    assign result_is_64_o = wide_reg;
    assign illegal_op_o = illegal_reg;
    assign predicate_write_o = 1'b0;

endmodule

// *** hdl/float_order.sv ***
/*
 * Ordered comparison of two IEEE values of parameter width.
 * Assumes operands come from logic on the same clock; purely combinational.
 * Denormal inputs are flushed to signed zero when flush_i is high.
 */
`timescale 1ns/1ps
module float_order #(
    parameter int W = 32,
    parameter int EXP_W = 8
) (
    // Operands
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic flush_i,
    // Relations
    output logic eq_o,
    output logic gt_o,
    output logic unordered_o
);
    logic [W-1:0] a_f;
    logic [W-1:0] b_f;
    logic a_nan;
    logic b_nan;
    logic both_zero;
    logic mag_gt;
    logic mag_lt;

    // Flush denormal to zero keeping sign
    always_comb
    begin
        a_f = a_i;
        b_f = b_i;
        if (flush_i && (a_i[W-2 -: EXP_W] == '0))
        begin
            a_f = {a_i[W-1], {(W-1){1'b0}}};
        end
        if (flush_i && (b_i[W-2 -: EXP_W] == '0))
        begin
            b_f = {b_i[W-1], {(W-1){1'b0}}};
        end
    end

    assign a_nan = (&a_f[W-2 -: EXP_W]) && (|a_f[W-EXP_W-2:0]);
    assign b_nan = (&b_f[W-2 -: EXP_W]) && (|b_f[W-EXP_W-2:0]);
    assign unordered_o = a_nan | b_nan;
    assign both_zero = (a_f[W-2:0] == '0) && (b_f[W-2:0] == '0);
    assign mag_gt = a_f[W-2:0] > b_f[W-2:0];
    assign mag_lt = a_f[W-2:0] < b_f[W-2:0];

    always_comb
    begin
        eq_o = 1'b0;
        gt_o = 1'b0;
        if (!unordered_o)
        begin
            if (both_zero)
            begin
                eq_o = 1'b1;
            end
            else if (a_f[W-1] != b_f[W-1])
            begin
                gt_o = !a_f[W-1];
            end
            else
            begin
                eq_o = (a_f == b_f);
                gt_o = a_f[W-1] ? mag_lt : mag_gt;
            end
        end
    end
endmodule

// *** sim/cmp_set_slot_sva.sv ***
/* Port checker for the compare-and-set slot.
   Assumes one clock domain, synchronous reset, and a bind by port name. */
`timescale 1ns/1ps
module cmp_set_slot_sva (
    // Clock, control and operands
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic issue_i,
    input wire logic [31:0] first_alu_word_i,
    input wire logic [31:0] second_alu_word_i,
    input wire logic clause_end_i,
    input wire logic [31:0] src0_i,
    input wire logic [31:0] src1_i,
    // Results and modes
    input wire logic result_valid_o,
    input wire logic [63:0] result_o,
    input wire logic result_is_64_o,
    input wire logic illegal_op_o,
    input wire logic predicate_write_o,
    input wire logic [1:0] single_round_o,
    input wire logic single_in_denorm_o,
    input wire logic single_out_denorm_o,
    input wire logic [1:0] double_round_o
);
    logic [10:0] opc;
    assign opc = second_alu_word_i[17:7];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_valid_latency: assert property (issue_i && clk_en_i && opc != 11'h057 |=> result_valid_o)
        else $error("result valid missing after issue");
    a_valid_cause: assert property ($past(clk_en_i) && result_valid_o |-> $past(issue_i) && $past(opc) != 11'h057)
        else $error("result valid without a compare issue");
    a_upper_zero: assert property (result_valid_o && !result_is_64_o |-> result_o[63:32] == 32'h0)
        else $error("upper half set on 32-bit result");
    a_result_form: assert property (result_valid_o |-> result_o inside {64'h0, 64'h3f800000, 64'hffffffff, 64'hffffffffffffffff})
        else $error("result not a set constant");
    a_wide_mask: assert property (result_valid_o && result_is_64_o |-> result_o[63:32] == result_o[31:0])
        else $error("64-bit mask halves differ");
    a_result_hold: assert property (!$past(sys_rst_i) && $past(clk_en_i) && !$past(issue_i) |-> $stable(result_o))
        else $error("result changed without issue");
    a_predicate_quiet: assert property (!predicate_write_o)
        else $error("predicate written");
    a_int_equal: assert property (issue_i && clk_en_i && opc == 11'h03a |=> result_o == (($past(src0_i) == $past(src1_i)) ? 64'hffffffff : 64'h0))
        else $error("integer equal mask wrong");
    a_signed_greater: assert property (issue_i && clk_en_i && opc == 11'h03b |=> result_o == (($signed($past(src0_i)) > $signed($past(src1_i))) ? 64'hffffffff : 64'h0))
        else $error("signed greater mask wrong");
    a_mode_load: assert property (issue_i && clk_en_i && opc == 11'h057 |=> single_round_o == $past(first_alu_word_i[1:0]) && double_round_o == $past(first_alu_word_i[14:13]))
        else $error("override round mode not loaded");
    a_clause_restore: assert property (clause_end_i && clk_en_i && !(issue_i && opc == 11'h057) |=> {single_out_denorm_o, single_in_denorm_o, single_round_o} == 4'hc)
        else $error("clause end did not restore modes");
    c_wide: cover property (result_valid_o && result_is_64_o);
    c_illegal: cover property (illegal_op_o);
    c_clause: cover property (clause_end_i && clk_en_i);
endmodule
bind cmp_set_slot cmp_set_slot_sva chk (.*);

// *** sim/cmp_set_slot_tb.sv ***
/* Self-checking bench for the compare-and-set slot.
   Assumes seq_model and the bound checker are compiled first. */
`timescale 1ns/1ps
module cmp_set_slot_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req = 1'b0;
    logic clause_end = 1'b0;
    logic flush = 1'b0;
    logic en = 1'b1;
    logic [63:0] rnd = 64'h0;
    logic [10:0] opc = 11'h0;
    logic [31:0] w0 = 32'h0;
    logic [63:0] opa = 64'h0;
    logic [63:0] opb = 64'h0;
    logic [63:0] seed = 64'h0000000000010630;
    logic issue, result_valid_o, result_is_64_o, illegal_op_o;
    logic [31:0] w0_q, w1_q;
    logic [63:0] a_q, b_q, result_o;
    logic [1:0] s_rnd, d_rnd;
    logic s_in, s_out, d_in, d_out;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [10:0] ops [18] = '{11'h008, 11'h009, 11'h00a, 11'h00b, 11'h00c, 11'h00d,
        11'h00e, 11'h00f, 11'h03a, 11'h03b, 11'h03c, 11'h03d, 11'h03e, 11'h03f,
        11'h0b8, 11'h0b9, 11'h0ba, 11'h0bb};
    logic [63:0] corners [6] = '{64'h0, 64'h8000000000000000, 64'h7ff8000000000000,
        64'h3ff0000000000000, 64'hbf80000000000000, 64'h3f80000000000000};
    always #50 clk_i = ~clk_i;
    seq_model seq (.clk_i(clk_i), .req_i(req), .op_i(opc), .w0_i(w0), .a_i(opa),
        .b_i(opb), .issue_o(issue), .w0_o(w0_q), .w1_o(w1_q), .a_o(a_q), .b_o(b_q));
    cmp_set_slot dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en),
        .issue_i(issue), .first_alu_word_i(w0_q), .second_alu_word_i(w1_q),
        .clause_end_i(clause_end), .src0_i(a_q[63:32]), .src1_i(b_q[63:32]),
        .src0_lo_i(a_q[31:0]), .src1_lo_i(b_q[31:0]), .result_valid_o(result_valid_o),
        .result_o(result_o), .result_is_64_o(result_is_64_o), .illegal_op_o(illegal_op_o),
        .predicate_write_o(), .single_round_o(s_rnd), .single_in_denorm_o(s_in),
        .single_out_denorm_o(s_out), .double_round_o(d_rnd), .double_in_denorm_o(d_in),
        .double_out_denorm_o(d_out));
    // ********************************************
    // Expectation and checking helpers
    // ********************************************
    function automatic logic [63:0] r64();
        repeat (64) seed = {seed[62:0], seed[63] ^ seed[62] ^ seed[60] ^ seed[59]};
        return seed;
    endfunction
    // Returns {greater, equal}; both low when unordered
    function automatic logic [1:0] rel(input logic [63:0] a, b, input logic d);
        logic [63:0] ka, kb;
        if (!d)
        begin
            a[31:0] = 32'h0;
            b[31:0] = 32'h0;
            if (flush && a[62:55] == 8'h0) a[54:32] = 23'h0;
            if (flush && b[62:55] == 8'h0) b[54:32] = 23'h0;
            if ((&a[62:55] && |a[54:32]) || (&b[62:55] && |b[54:32])) return 2'h0;
        end
        else if ((&a[62:52] && |a[51:0]) || (&b[62:52] && |b[51:0])) return 2'h0;
        if (a[62:0] == 63'h0 && b[62:0] == 63'h0) return 2'h1;
        ka = a[63] ? ~a : a ^ 64'h8000000000000000;
        kb = b[63] ? ~b : b ^ 64'h8000000000000000;
        return {ka > kb, ka == kb};
    endfunction
    function automatic logic [63:0] expv(input logic [10:0] op, input logic [63:0] a, b);
        logic [1:0] r;
        logic [31:0] x, y;
        logic t;
        r = rel(a, b, op[7]);
        x = a[63:32];
        y = b[63:32];
        case (op)
            11'h008, 11'h00c: t = r[0];
            11'h009, 11'h00d, 11'h0ba: t = r[1];
            11'h00a, 11'h00e, 11'h0b8, 11'h0bb: t = |r;
            11'h00b, 11'h00f, 11'h0b9: t = !r[0];
            11'h03a: t = x == y;
            11'h03d: t = x != y;
            11'h03b: t = $signed(x) > $signed(y);
            11'h03c: t = $signed(x) >= $signed(y);
            11'h03e: t = x > y;
            default: t = x >= y;
        endcase
        if (op[7]) return {64{t}};
        if (op < 11'h00c) return t ? 64'h3f800000 : 64'h0;
        return {32'h0, {32{t}}};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run(input logic [10:0] op, input logic [31:0] w, input logic [63:0] a,
        input logic [63:0] b, input logic ill);
        int k;
        k = 0;
        @(posedge clk_i);
        req <= 1'b1;
        opc <= op;
        w0 <= w;
        opa <= a;
        opb <= b;
        @(posedge clk_i);
        req <= 1'b0;
        do
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        while (op != 11'h057 && result_valid_o !== 1'b1 && k < 8);
        chk({63'h0, result_valid_o}, {63'h0, op != 11'h057});
        if (op != 11'h057)
        begin
            chk(result_o, ill ? 64'h0 : expv(op, a, b));
            chk({62'h0, result_is_64_o, illegal_op_o}, {62'h0, op[7] & ~ill, ill});
        end
    endtask
    task automatic modes(input logic [7:0] exp);
        chk({56'h0, d_out, d_in, d_rnd, s_out, s_in, s_rnd}, {56'h0, exp});
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            final_report;
        end
    end
    // ********************************************
    // Scenarios
    // ********************************************
    initial
    begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        modes(8'hcc);
        for (int c = 0; c < 6; c += 2)
            foreach (ops[i]) run(ops[i], 32'h0, corners[c], corners[c + 1], 1'b0);
        for (int t = 0; t < 8; t++)
            foreach (ops[i])
            begin
                rnd = r64();
                run(ops[i], 32'h0, rnd, t[0] ? rnd : r64(), 1'b0);
            end
        run(11'h010, 32'h0, 64'h0, 64'h0, 1'b1);
        run(11'h7ff, 32'h0, 64'h1, 64'h1, 1'b1);
        for (int i = 15; i >= 0; i--)
        begin
            run(11'h057, {15'h0, 4'(~i), 9'h0, 4'(i)}, 64'h0, 64'h0, 1'b0);
            modes({4'(~i), 4'(i)});
        end
        // Enable low freezes modes despite a clause end
        @(posedge clk_i);
        en <= 1'b0;
        clause_end <= 1'b1;
        repeat (2) @(posedge clk_i);
        en <= 1'b1;
        #1;
        modes(8'hf0);
        // Override beats a clause end in the same cycle
        run(11'h057, {15'h0, 4'h3, 13'h0}, 64'h0, 64'h0, 1'b0);
        clause_end <= 1'b0;
        modes(8'h30);
        flush = 1'b1;
        run(11'h008, 32'h0, 64'h0000000100000000, 64'h0, 1'b0);
        @(posedge clk_i);
        clause_end <= 1'b1;
        @(posedge clk_i);
        clause_end <= 1'b0;
        @(posedge clk_i);
        #1;
        modes(8'hcc);
        flush = 1'b0;
        run(11'h008, 32'h0, 64'h0000000100000000, 64'h0, 1'b0);
        final_report;
    end
endmodule

// *** sim/seq_model.sv ***
/* Sequencer model: presents whole instruction words and operand pairs.
   Assumes the bench raises req_i for one cycle per instruction. */
`timescale 1ns/1ps
module seq_model (
    // Requests from bench
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [10:0] op_i,
    input wire logic [31:0] w0_i,
    input wire logic [63:0] a_i,
    input wire logic [63:0] b_i,
    // Issue side
    output logic issue_o,
    output logic [31:0] w0_o,
    output logic [31:0] w1_o,
    output logic [63:0] a_o,
    output logic [63:0] b_o
);
    // Idle lines invert so stale operands never pass for live ones
    always_ff @(posedge clk_i)
    begin
        issue_o <= req_i;
        w0_o <= req_i ? w0_i : ~w0_o;
        w1_o <= req_i ? {14'h0, op_i, 7'h0} : ~w1_o;
        a_o <= req_i ? a_i : ~a_o;
        b_o <= req_i ? b_i : ~b_o;
    end
endmodule
